// ---- pkg/bci_pkg.sv ----
// constants, field layout and carrier types of the bridge control block
// assumes an ahb-lite slave with word registers at four times their index
package bci_pkg;

   // ==================================================
   // register indices, byte address is four times these
   localparam logic [7:0] IDX_IND_CTL = 8'h40;
   localparam logic [7:0] IDX_IND_OFF = 8'h41;
   localparam logic [7:0] IDX_IND_DATA = 8'h42;
   localparam logic [7:0] IDX_BRIDGE = 8'h4f;
   localparam logic [7:0] IDX_LINK_SEL = 8'h60;

   // ==================================================
   // field positions
   localparam int BC_CONT_CLK = 7;
   localparam int BC_DUAL = 6;
   localparam int BC_PORT_SEL = 5;
   localparam int BC_STEREO = 4;
   localparam int BC_LANES_LO = 2;
   localparam int BC_CFG_INIT = 1;
   localparam int IC_PAGE_LO = 2;
   localparam int IC_STEP = 1;
   localparam int IC_READ = 0;

   // ==================================================
   // encodings and reset values
   localparam logic [2:0] PAGE_OFF = 3'h0;
   localparam logic [2:0] PAGE_RX0 = 3'h1;
   localparam logic [2:0] PAGE_RX1 = 3'h2;
   localparam logic [7:0] IND_OFF_RST = 8'h00;
   localparam logic [4:0] IND_CTL_RST = 5'h00;
   localparam logic [7:0] PAGE_RST = 8'h00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam int NVM_LOAD_DEFAULT = 16;

   typedef struct packed {
      logic cont_clk;
      logic [1:0] lanes;
   } bci_link_cfg_s;

   typedef struct packed {
      logic dual;
      logic port_sel;
      logic stereo;
   } bci_rx_cfg_s;

   localparam bci_link_cfg_s LINK_CFG_RST = 3'h0;
   localparam bci_rx_cfg_s RX_CFG_RST = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOAD = 3'b010,
      ST_APPLY = 3'b100
   } bci_cfg_state_e;

endpackage

// ---- design/bci_bridge_control.sv ----
// bridge control register bank with indirect page window
// assumes a single ahb-lite master, word transfers, straps from pins
`timescale 1ns/1ps
`default_nettype none
module bci_bridge_control
   import bci_pkg::*;
#(
   parameter int PAGE_WORDS = 16,
   parameter int NVM_LOAD_CYCLES = NVM_LOAD_DEFAULT
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [1:0] strap_pin_a,
   input wire logic strap_pin_b,
   input wire logic indep_mode,
   output logic [1:0] cont_clk_mode,
   output logic [3:0] lane_enable0,
   output logic [3:0] lane_enable1,
   output logic rx_dual_mode,
   output logic rx_input_sel,
   output logic rx_port_swap,
   output logic line_interleaved_stereo,
   output logic cfg_busy
);

   localparam int OW = $clog2(PAGE_WORDS);
   localparam int CW = $clog2(NVM_LOAD_CYCLES + 1);
   localparam int LOAD_MAX = NVM_LOAD_CYCLES + 2;
   localparam logic [CW-1:0] LOAD_LAST = CW'(NVM_LOAD_CYCLES - 1);

   function automatic logic [3:0] lanes_to_en(input logic [1:0] l);
      lanes_to_en = (l == 2'h0) ? 4'h1 : (l == 2'h1) ? 4'h3 :
                    (l == 2'h2) ? 4'h7 : 4'hf;
   endfunction

   // ==================================================
   // bus slave
   logic rd_pend_q, wr_pend_q;
   logic [7:0] idx_q;
   wire take = hsel && hready && htrans[1];
   wire addr_ok = (haddr[31:10] == 22'h0);
   wire [7:0] wd = hwdata[7:0];
   wire wr_ctl = wr_pend_q && (idx_q == IDX_IND_CTL);
   wire wr_off = wr_pend_q && (idx_q == IDX_IND_OFF);
   wire wr_dat = wr_pend_q && (idx_q == IDX_IND_DATA);
   wire wr_bc = wr_pend_q && (idx_q == IDX_BRIDGE);
   wire wr_ls = wr_pend_q && (idx_q == IDX_LINK_SEL);
   wire rd_dat = rd_pend_q && (idx_q == IDX_IND_DATA);

   // reads take one wait state so a write just before is already visible
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
         idx_q <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         rd_pend_q <= take && !hwrite;
         wr_pend_q <= take && hwrite && addr_ok;
         hreadyout <= !(take && !hwrite);
         hresp <= 1'b0;
         if (take)
            idx_q <= addr_ok ? haddr[9:2] : 8'hff;
      end
   end

   // ==================================================
   // indirect window
   logic [7:0] off_q;
   logic [4:0] ictl_q;
   logic [7:0] pg_q [2][PAGE_WORDS];
   wire [2:0] page = ictl_q[IC_PAGE_LO +: 3];
   wire step_en = ictl_q[IC_STEP];
   wire pidx = (page == PAGE_RX1);
   wire [OW-1:0] oidx = off_q[OW-1:0];
   wire page_on = (page == PAGE_RX0) || (page == PAGE_RX1);
   wire ind_hit = page_on && ({24'h0, off_q} < PAGE_WORDS);
   wire [7:0] ind_rd = ind_hit ? pg_q[pidx][oidx] : 8'h00;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         off_q <= IND_OFF_RST;
         ictl_q <= IND_CTL_RST;
      end
      else
      begin
         if (wr_ctl)
            ictl_q <= wd[4:0];
         if (wr_off)
            off_q <= wd;
         else if ((wr_dat || rd_dat) && step_en)
            off_q <= off_q + 8'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int p = 0; p < 2; p++)
            for (int w = 0; w < PAGE_WORDS; w++)
               pg_q[p][w] <= PAGE_RST;
      end
      else if (wr_dat && ind_hit)
         pg_q[pidx][oidx] <= wd;
   end

   // ==================================================
   // strap synchronisers and reload sequencer
   logic [1:0] sa_s1, sa_s2;
   logic sb_s1, sb_s2;
   bci_cfg_state_e st_q;
   logic [CW-1:0] cnt_q;
   logic cfg_init_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sa_s1 <= 2'h0;
         sa_s2 <= 2'h0;
         sb_s1 <= 1'b0;
         sb_s2 <= 1'b0;
      end
      else
      begin
         sa_s1 <= strap_pin_a;
         sa_s2 <= sa_s1;
         sb_s1 <= strap_pin_b;
         sb_s2 <= sb_s1;
      end
   end

   // after reset the sequencer runs a load so straps are taken post-release
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q <= ST_LOAD;
         cnt_q <= '0;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
            begin
               cnt_q <= '0;
               if (cfg_init_q)
                  st_q <= ST_LOAD;
            end
            ST_LOAD:
            begin
               cnt_q <= cnt_q + CW'(1);
               if (cnt_q == LOAD_LAST)
                  st_q <= ST_APPLY;
            end
            ST_APPLY:
               st_q <= ST_IDLE;
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   // a new request in the finishing cycle wins over the self-clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cfg_init_q <= 1'b0;
      else if (wr_bc && wd[BC_CFG_INIT])
         cfg_init_q <= 1'b1;
      else if (st_q == ST_APPLY)
         cfg_init_q <= 1'b0;
   end

   // ==================================================
   // bridge control fields, link fields strap-backed with one copy per output link, rx fields one shared copy
   bci_link_cfg_s link_q [2];
   bci_rx_cfg_s rx_q;
   logic link_sel_q;
   wire view = indep_mode && link_sel_q;
   wire bci_link_cfg_s link_v = link_q[view];
   wire [7:0] bc_rd = {link_v.cont_clk, rx_q.dual, rx_q.port_sel,
                       rx_q.stereo, link_v.lanes, cfg_init_q, 1'b0};

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gen_link
         wire mine = !indep_mode || (link_sel_q == 1'(g));
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               link_q[g] <= LINK_CFG_RST;
            else if (st_q == ST_APPLY)
               link_q[g] <= '{cont_clk: sb_s2, lanes: sa_s2};
            else if (wr_bc && mine)
               link_q[g] <= '{cont_clk: wd[BC_CONT_CLK],
                              lanes: wd[BC_LANES_LO +: 2]};
         end
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_q <= RX_CFG_RST;
         link_sel_q <= 1'b0;
      end
      else
      begin
         if (wr_bc)
            rx_q <= '{dual: wd[BC_DUAL], port_sel: wd[BC_PORT_SEL],
                      stereo: wd[BC_STEREO]};
         if (wr_ls)
            link_sel_q <= wd[0];
      end
   end

   // ==================================================
   // read data and registered outputs
   wire [7:0] rd_val =
      (idx_q == IDX_IND_CTL) ? {3'h0, ictl_q} :
      (idx_q == IDX_IND_OFF) ? off_q :
      (idx_q == IDX_IND_DATA) ? ind_rd :
      (idx_q == IDX_BRIDGE) ? bc_rd :
      (idx_q == IDX_LINK_SEL) ? {7'h00, link_sel_q} : 8'h00;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h0;
         cont_clk_mode <= 2'h0;
         lane_enable0 <= 4'h0;
         lane_enable1 <= 4'h0;
         rx_dual_mode <= 1'b0;
         rx_input_sel <= 1'b0;
         rx_port_swap <= 1'b0;
         line_interleaved_stereo <= 1'b0;
         cfg_busy <= 1'b1;
      end
      else
      begin
         if (rd_pend_q)
            hrdata <= {24'h0, rd_val};
         cont_clk_mode <= {link_q[1].cont_clk, link_q[0].cont_clk};
         lane_enable0 <= lanes_to_en(link_q[0].lanes);
         lane_enable1 <= lanes_to_en(link_q[1].lanes);
         rx_dual_mode <= rx_q.dual;
         rx_input_sel <= !rx_q.dual && !indep_mode && rx_q.port_sel;
         rx_port_swap <= indep_mode && rx_q.port_sel;
         line_interleaved_stereo <= rx_q.stereo;
         cfg_busy <= (st_q != ST_IDLE) || cfg_init_q;
      end
   end

   // ==================================================
   // checks
   a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      hresp == 1'b0)
      else $error("response not okay");
   a_ind_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_dat && ind_hit |=> pg_q[$past(pidx)][$past(oidx)] == $past(wd))
      else $error("indirect write lost");
   a_ind_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_dat && !ind_hit |=> hrdata == 32'h0)
      else $error("disabled page read not zero");
   a_step_inc: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_dat || rd_dat) && step_en |=> off_q == $past(off_q) + 8'h01)
      else $error("offset did not step");
   a_load_bound: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(st_q == ST_LOAD) |-> ##[1:LOAD_MAX] st_q == ST_APPLY)
      else $error("reload too long");
   a_strap_back: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q == ST_APPLY |=> link_q[0].lanes == $past(sa_s2)
         && link_q[1].cont_clk == $past(sb_s2))
      else $error("strap value not restored");
   a_init_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(cfg_init_q) |-> $past(st_q == ST_APPLY))
      else $error("cfg init cleared early");
   a_lane_map: assert property (@(posedge hclk) disable iff (!hresetn)
      hresetn |=> lane_enable1 == lanes_to_en($past(link_q[1].lanes)))
      else $error("lane enable mismatch");
   a_rsvd_lsb: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_pend_q && idx_q == IDX_BRIDGE |=> hrdata[0] == 1'b0)
      else $error("reserved bit set");
   a_swap_map: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_port_swap |-> $past(indep_mode && rx_q.port_sel))
      else $error("swap without cause");

endmodule
`default_nettype wire

// ---- verif/bci_bridge_control_test.sv ----
// self-checking bench for the bridge control register bank
// assumes the bench is the only ahb-lite master and drives the straps
`timescale 1ns/1ps
`default_nettype none
module bci_bridge_control_test
   import bci_pkg::*;
;
   typedef struct packed {
      logic wr;
      logic [11:0] a;
      logic [8:0] d;
   } bci_row_s;
   logic hclk, hresetn, hsel, hwrite, strap_pin_b, indep_mode;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, strap_pin_a, cont_clk_mode;
   logic [2:0] hsize;
   logic [3:0] lane_enable0, lane_enable1;
   logic hreadyout, hresp, rx_dual_mode, rx_input_sel, rx_port_swap;
   logic line_interleaved_stereo, cfg_busy;
   wire logic hready;
   int failures, total_checks;
   // a read of a write-only row is never made: wr rows only drive the bus
   bci_row_s rows [0:29] = '{
      '{1'b1, 12'h104, 9'h1a5}, '{1'b0, 12'h104, 9'h0a5},
      '{1'b1, 12'h3f0, 9'h055}, '{1'b0, 12'h3f0, 9'h000},
      '{1'b1, 12'h400, 9'h077}, '{1'b0, 12'h400, 9'h000},
      '{1'b1, 12'h13c, 9'h0dd}, '{1'b0, 12'h13c, 9'h0dc},
      '{1'b1, 12'h100, 9'h0ff}, '{1'b0, 12'h100, 9'h01f},
      '{1'b1, 12'h100, 9'h006}, '{1'b1, 12'h104, 9'h003},
      '{1'b1, 12'h108, 9'h05a}, '{1'b0, 12'h104, 9'h004},
      '{1'b1, 12'h104, 9'h003}, '{1'b0, 12'h108, 9'h05a},
      '{1'b0, 12'h104, 9'h004}, '{1'b1, 12'h100, 9'h008},
      '{1'b1, 12'h104, 9'h003}, '{1'b0, 12'h108, 9'h000},
      '{1'b1, 12'h100, 9'h00c}, '{1'b1, 12'h108, 9'h022},
      '{1'b0, 12'h108, 9'h000}, '{1'b1, 12'h100, 9'h000},
      '{1'b1, 12'h108, 9'h011}, '{1'b0, 12'h108, 9'h000},
      '{1'b1, 12'h100, 9'h004}, '{1'b0, 12'h108, 9'h05a},
      '{1'b1, 12'h100, 9'h000}, '{1'b0, 12'h108, 9'h000}
   };
   assign hready = hreadyout;
   bci_bridge_control #(.PAGE_WORDS(16), .NVM_LOAD_CYCLES(3)) bci_bridge_control_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .strap_pin_a(strap_pin_a),
      .strap_pin_b(strap_pin_b), .indep_mode(indep_mode),
      .cont_clk_mode(cont_clk_mode), .lane_enable0(lane_enable0),
      .lane_enable1(lane_enable1), .rx_dual_mode(rx_dual_mode),
      .rx_input_sel(rx_input_sel), .rx_port_swap(rx_port_swap),
      .line_interleaved_stereo(line_interleaved_stereo),
      .cfg_busy(cfg_busy));
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   // ==========================================
   // tasks
   task automatic stop_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic timeout;
      failures++;
      $display("ERROR %0t: wait ran out", $time);
      stop_test();
   endtask
   // called right after a rising edge; ends on the edge that sees ready
   task automatic wait_ready;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
         if (n > 50)
            timeout();
      end
      while (hreadyout !== 1'b1);
   endtask
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (cfg_busy !== lvl)
      begin
         @(posedge hclk);
         n++;
         if (n > 200)
            timeout();
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a,
         input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      r = hrdata;
   endtask
   task automatic settle;
      repeat (2) @(posedge hclk);
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      hresetn = 1'b0;
      {hsel, hwrite, indep_mode} = 3'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      strap_pin_a = 2'h2;
      strap_pin_b = 1'b1;
      repeat (16) @(posedge hclk);
      chk(32'({hreadyout, hresp, cfg_busy, lane_enable0}), 32'h0000005 << 4);
      hresetn <= 1'b1;
      wait_busy(1'b0);
      bus(1'b0, 32'h13c, 32'h0, rd);
      chk(rd, 32'h88);
      chk(32'({cont_clk_mode, lane_enable0, lane_enable1}), 32'h377);
      $display("test reset and straps done");
      foreach (rows[i])
      begin
         bus(rows[i].wr, 32'(rows[i].a), 32'(rows[i].d), rd);
         if (!rows[i].wr)
            chk(rd, 32'(rows[i].d));
      end
      $display("test register table done");
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, 32'h13c, 32'(i << 2), rd);
         settle();
         chk(32'(lane_enable0), (32'h2 << i) - 32'h1);
      end
      $display("test lane field done");
      // outputs packed as dual, input select, swap, stereo
      bus(1'b1, 32'h13c, 32'hb0, rd);
      settle();
      chk(32'({rx_dual_mode, rx_input_sel, rx_port_swap,
            line_interleaved_stereo}), 32'h5);
      chk(32'(cont_clk_mode), 32'h3);
      indep_mode <= 1'b1;
      settle();
      chk(32'({rx_input_sel, rx_port_swap}), 32'h1);
      indep_mode <= 1'b0;
      bus(1'b1, 32'h13c, 32'h40, rd);
      settle();
      chk(32'({rx_dual_mode, rx_input_sel}), 32'h2);
      $display("test mode bits done");
      strap_pin_a <= 2'h1;
      strap_pin_b <= 1'b0;
      bus(1'b1, 32'h13c, 32'h92, rd);
      wait_busy(1'b1);
      wait_busy(1'b0);
      bus(1'b0, 32'h13c, 32'h0, rd);
      chk(rd, 32'h14);
      $display("test reload done");
      indep_mode <= 1'b1;
      bus(1'b1, 32'h180, 32'h1, rd);
      bus(1'b1, 32'h13c, 32'h8c, rd);
      settle();
      chk(32'({cont_clk_mode, lane_enable1, lane_enable0}), 32'h2f3);
      bus(1'b0, 32'h13c, 32'h0, rd);
      chk(rd, 32'h8c);
      bus(1'b1, 32'h180, 32'h0, rd);
      bus(1'b0, 32'h13c, 32'h0, rd);
      chk(rd, 32'h04);
      $display("test link copies done");
      stop_test();
   end
endmodule
`default_nettype wire
